/* File: verilog/ies_regs.svh */
// Constants of the supervisor with serial EEPROM: timing, field positions, codes.
// Assumes a single 50 MHz reference clock; included by the package and the top.
//
// What this block does
// - Hold reset while supply is bad and about 200 ms after it recovers.
// - Assert reset whenever the supply-good indication drops.
// - A falling edge driven onto the reset pin starts a fresh timeout.
// - A short external reset pulse still yields at least the full timeout.
// - Reset holds while manual reset is low, then one full timeout more.
// - Manual reset low pulses under 100 ns cause no reset.
// - Reset aborts serial transactions and refuses new ones until released.
// - Reset starts no programming but lets a running one finish.
// - No edge on the watched line for 1.6 s causes reset; edges clear it.
// - Watchdog counter stays cleared and stopped while reset is asserted.
// - Bus activity is ignored until a START condition.
// - SDA changes only while SCL is low; changes with SCL high are conditions.
// - Upper address nibble must match the type code; bit zero selects read.
// - The receiver pulls SDA low on the ninth clock to acknowledge.
// - Acknowledge a matching address and every written byte.
// - After each read byte, sample acknowledge; continue if given, else wait.
// - Byte write is address, word address, data, then STOP starts programming.
// - Page write takes 16 bytes, stepping only the low address bits.
// - Beyond 16 bytes the in-page address wraps; one cycle programs all.
// - No address acknowledge while programming, so the master can poll.
// - With write protect high, nack the first data byte and program nothing.
// - Programming finishes within 5 ms of the STOP.
// - Address counter points one past last access; reads wrap 255 to 0.
`ifndef IES_REGS_SVH
`define IES_REGS_SVH

`define IES_CLK_MHZ      50
`define IES_CLK_NS       20
`define IES_T_PURST_US   200000
`define IES_T_WD_US      1600000
`define IES_T_WC_US      5000
`define IES_T_MR_NS      100
`define IES_TYPE_CODE    4'ha
`define IES_DRAIN_TICK   2'h3
`define IES_MIN_WC_CYC   128

// Synchroniser lanes
`define IES_SY_SCL   0
`define IES_SY_SDA   1
`define IES_SY_RSTP  2
`define IES_SY_MR    3
`define IES_SY_KICK  4
`define IES_SY_WP    5
`define IES_SY_PG    6
`define IES_SY_N     7

`endif

/* File: verilog/ies_pkg.sv */
// Types of the supervisor top; ies_wr_type is the entry of its write FIFO.
// Assumes ies_regs.svh is on the include path.
`include "ies_regs.svh"
package ies_pkg;

   // Serial slave states, Gray along idle-receive-ack-transmit
   typedef enum logic [2:0] {
      IES_IDLE  = 3'b000,
      IES_RX    = 3'b001,
      IES_ACK   = 3'b011,
      IES_TX    = 3'b010,
      IES_TXACK = 3'b110,
      IES_WAIT  = 3'b111
   } ies_st_type;

   typedef enum logic [1:0] {
      IES_PH_ADDR = 2'b00,
      IES_PH_WORD = 2'b01,
      IES_PH_DATA = 2'b11
   } ies_phase_type;

   // One byte bound for the array
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } ies_wr_type;

endpackage : ies_pkg

/* File: verilog/ies_top.sv */
// Supervisor with reset controller, watchdog and I2C slave EEPROM of 256 bytes.
// Assumes all pins are asynchronous to ref_clk and an external pull-up on SDA.
`timescale 1ns/1ps
`include "ies_regs.svh"

// ----------------------------------------------------------------------------
// Write FIFO between page buffer and array
// ----------------------------------------------------------------------------
module ies_fifo #(
   parameter int unsigned W     = 16,
   parameter int unsigned DEPTH = 16
) (
   // Clock and reset
   input  wire logic         ref_clk,
   input  wire logic         rst_n,
   // Fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // Drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int unsigned AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } ies_fifo_state_type;

   ies_fifo_state_type s_q, s_d;

   if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
      $error("ies_fifo: DEPTH must be a power of two");
   end

   assign in_ready  = (s_q.wp - s_q.rp) != (AW+1)'(DEPTH);
   assign out_valid = s_q.wp != s_q.rp;
   assign out_data  = s_q.mem[s_q.rp[AW-1:0]];

   always_comb begin
      s_d = s_q;
      if (in_valid && in_ready) begin
         s_d.mem[s_q.wp[AW-1:0]] = in_data;
         s_d.wp = s_q.wp + 1'b1;
      end
      if (out_valid && out_ready) begin
         s_d.rp = s_q.rp + 1'b1;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule : ies_fifo

// ----------------------------------------------------------------------------
// Supervisor top
// ----------------------------------------------------------------------------
module ies_top #(
   parameter int unsigned PURST_CYC  = `IES_T_PURST_US * `IES_CLK_MHZ,
   parameter int unsigned WD_CYC     = `IES_T_WD_US * `IES_CLK_MHZ,
   parameter int unsigned WC_CYC     = `IES_T_WC_US * `IES_CLK_MHZ,
   parameter logic [3:0]  TYPE_CODE  = `IES_TYPE_CODE,
   parameter int unsigned FIFO_DEPTH = 16
) (
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic rst_n,
   // Supply and reset pins
   input  wire logic supply_good,
   input  wire logic manual_reset_n,
   input  wire logic reset_n_sense,
   output logic      reset_n_level,
   output logic      reset_n_oe,
   output logic      reset_hi,
   // Watchdog
   input  wire logic watchdog_kick_input,
   input  wire logic wd_watch_kick,
   // Serial link
   input  wire logic scl,
   input  wire logic sda_sense,
   output logic      sda_level,
   output logic      sda_oe,
   input  wire logic write_protect,
   // Status
   output logic      prog_busy
);
   import ies_pkg::*;

   // Pulses under the glitch width can straddle that many samples, so one more
   localparam int unsigned MR_CYC = `IES_T_MR_NS / `IES_CLK_NS + 1;

   if (PURST_CYC < 2 || WD_CYC < 2 || WC_CYC < `IES_MIN_WC_CYC || FIFO_DEPTH < 16)
   begin : g_chk
      $error("ies_top: timing counts too small for the logic");
   end

   typedef struct packed {
      logic [`IES_SY_N-1:0] sy1;
      logic [`IES_SY_N-1:0] sy2;
      logic [`IES_SY_N-1:0] sy3;
      logic [31:0]          rcnt;
      logic                 rst_act;
      logic                 rst_oe;
      logic [31:0]          wdcnt;
      logic [7:0]           mrcnt;
      logic                 mr_low;
      ies_st_type           st;
      ies_phase_type        ph;
      logic                 rw;
      logic [3:0]           bcnt;
      logic [7:0]           sh;
      logic [7:0]           ptr;
      logic                 acked;
      logic                 sda_oe;
      logic [15:0]          pend;
      logic [15:0][7:0]     page;
      logic                 busy;
      logic                 commit;
      logic [3:0]           cidx;
      logic [31:0]          pcnt;
      logic [1:0]           div;
      logic                 lo;
      logic [255:0][7:0]    mem;
   } ies_state_type;

   ies_state_type s_q, s_d;

   // ------------------------------------------------------------------------
   // Synchronised views and conditions
   // ------------------------------------------------------------------------
   logic scl_s, scl_p, sda_s, sda_p;
   logic scl_rise, scl_fall, start_c, stop_c;
   logic pg_s, mr_s, wp_s, ext_fall, mon_edge, wd_to, trig;

   assign scl_s    = s_q.sy2[`IES_SY_SCL];
   assign scl_p    = s_q.sy3[`IES_SY_SCL];
   assign sda_s    = s_q.sy2[`IES_SY_SDA];
   assign sda_p    = s_q.sy3[`IES_SY_SDA];
   assign scl_rise = scl_s && !scl_p;
   assign scl_fall = !scl_s && scl_p;
   assign start_c  = scl_s && scl_p && sda_p && !sda_s;
   assign stop_c   = scl_s && scl_p && !sda_p && sda_s;
   assign pg_s     = s_q.sy2[`IES_SY_PG];
   assign mr_s     = s_q.sy2[`IES_SY_MR];
   assign wp_s     = s_q.sy2[`IES_SY_WP];
   // Own drive also pulls the pin low; only a foreign edge counts
   assign ext_fall = s_q.sy3[`IES_SY_RSTP] && !s_q.sy2[`IES_SY_RSTP]
                     && !s_q.rst_oe;
   assign mon_edge = wd_watch_kick ?
                     (s_q.sy2[`IES_SY_KICK] != s_q.sy3[`IES_SY_KICK]) :
                     (sda_s != sda_p);
   assign wd_to    = s_q.wdcnt >= WD_CYC - 1;
   assign trig     = !pg_s || s_q.mr_low || ext_fall || wd_to;

   // ------------------------------------------------------------------------
   // Write FIFO
   // ------------------------------------------------------------------------
   ies_wr_type ff_in, ff_out;
   logic       ff_in_valid, ff_in_ready, ff_out_valid, ff_pop;

   assign ff_in.addr  = {s_q.ptr[7:4], s_q.cidx};
   assign ff_in.data  = s_q.page[s_q.cidx];
   assign ff_in_valid = s_q.commit && s_q.pend[s_q.cidx];
   // Drain is rate-limited so the commit side can meet back-pressure
   assign ff_pop      = ff_out_valid && s_q.div == `IES_DRAIN_TICK;

   ies_fifo #(
      .W     ($bits(ies_wr_type)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .in_valid  (ff_in_valid),
      .in_ready  (ff_in_ready),
      .in_data   (ff_in),
      .out_valid (ff_out_valid),
      .out_ready (ff_pop),
      .out_data  (ff_out)
   );

   // ------------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------------
   always_comb begin
      s_d     = s_q;
      s_d.sy1 = {supply_good, write_protect, watchdog_kick_input, manual_reset_n,
                 reset_n_sense, sda_sense, scl};
      s_d.sy2 = s_q.sy1;
      s_d.sy3 = s_q.sy2;
      s_d.lo  = 1'b0;

      // Manual reset filter
      if (!mr_s) begin
         if (s_q.mrcnt < 8'(MR_CYC)) begin
            s_d.mrcnt = s_q.mrcnt + 8'h01;
         end
      end else begin
         s_d.mrcnt = 8'h00;
      end
      s_d.mr_low = !mr_s && (s_q.mrcnt >= 8'(MR_CYC - 1));

      // Reset timer: any trigger reloads the full timeout
      if (trig) begin
         s_d.rcnt = 32'(PURST_CYC);
      end else if (s_q.rcnt != 32'h0) begin
         s_d.rcnt = s_q.rcnt - 32'h1;
      end
      s_d.rst_act = trig || s_q.rcnt != 32'h0;
      s_d.rst_oe  = s_d.rst_act;

      // Watchdog
      if (s_q.rst_act || s_d.rst_act || mon_edge) begin
         s_d.wdcnt = 32'h0;
      end else begin
         s_d.wdcnt = s_q.wdcnt + 32'h1;
      end

      // Serial slave
      if (s_q.rst_act) begin
         s_d.st = IES_IDLE;
         if (!s_q.commit) begin
            s_d.pend = '0;
         end
      end else if (start_c) begin
         s_d.st   = IES_RX;
         s_d.ph   = IES_PH_ADDR;
         s_d.bcnt = 4'h0;
         if (!s_q.busy) begin
            s_d.pend = '0;
         end
      end else if (stop_c) begin
         s_d.st = IES_IDLE;
         if (s_q.pend != '0 && !s_q.busy) begin
            s_d.commit = 1'b1;
            s_d.busy   = 1'b1;
            s_d.cidx   = 4'h0;
            s_d.pcnt   = 32'h0;
         end
      end else begin
         unique case (s_q.st)
            IES_IDLE, IES_WAIT: begin
            end
            IES_RX: begin
               if (scl_rise && s_q.bcnt != 4'h8) begin
                  s_d.sh   = {s_q.sh[6:0], sda_s};
                  s_d.bcnt = s_q.bcnt + 4'h1;
               end else if (scl_fall && s_q.bcnt == 4'h8) begin
                  unique case (s_q.ph)
                     IES_PH_ADDR: begin
                        if (s_q.sh[7:4] == TYPE_CODE && !s_q.busy) begin
                           s_d.rw = s_q.sh[0];
                           s_d.st = IES_ACK;
                        end else begin
                           s_d.st = IES_WAIT;
                        end
                     end
                     IES_PH_WORD: begin
                        s_d.ptr = s_q.sh;
                        s_d.ph  = IES_PH_DATA;
                        s_d.st  = IES_ACK;
                     end
                     IES_PH_DATA: begin
                        if (wp_s) begin
                           s_d.st = IES_WAIT;
                        end else begin
                           s_d.page[s_q.ptr[3:0]] = s_q.sh;
                           s_d.pend[s_q.ptr[3:0]] = 1'b1;
                           s_d.ptr[3:0] = s_q.ptr[3:0] + 4'h1;
                           s_d.st = IES_ACK;
                        end
                     end
                     default: s_d.st = IES_WAIT;
                  endcase
               end
            end
            IES_ACK: begin
               if (scl_fall) begin
                  s_d.bcnt = 4'h0;
                  if (s_q.ph == IES_PH_ADDR && s_q.rw) begin
                     s_d.sh  = s_q.mem[s_q.ptr];
                     s_d.ptr = s_q.ptr + 8'h01;
                     s_d.st  = IES_TX;
                  end else begin
                     if (s_q.ph == IES_PH_ADDR) begin
                        s_d.ph = IES_PH_WORD;
                     end
                     s_d.st = IES_RX;
                  end
               end
            end
            IES_TX: begin
               if (scl_fall) begin
                  if (s_q.bcnt == 4'h7) begin
                     s_d.st = IES_TXACK;
                  end else begin
                     s_d.sh   = {s_q.sh[6:0], 1'b0};
                     s_d.bcnt = s_q.bcnt + 4'h1;
                  end
               end
            end
            IES_TXACK: begin
               if (scl_rise) begin
                  s_d.acked = !sda_s;
               end else if (scl_fall) begin
                  if (s_q.acked) begin
                     s_d.sh   = s_q.mem[s_q.ptr];
                     s_d.ptr  = s_q.ptr + 8'h01;
                     s_d.bcnt = 4'h0;
                     s_d.st   = IES_TX;
                  end else begin
                     s_d.st = IES_WAIT;
                  end
               end
            end
            default: s_d.st = IES_IDLE;
         endcase
      end
      // Drive changes only while SCL is low; state changes follow SCL edges
      s_d.sda_oe = s_d.st == IES_ACK || (s_d.st == IES_TX && !s_d.sh[7]);

      // Programming engine, deliberately not gated by reset
      if (s_q.commit && (ff_in_ready || !s_q.pend[s_q.cidx])) begin
         s_d.pend[s_q.cidx] = 1'b0;
         s_d.cidx = s_q.cidx + 4'h1;
         if (s_q.cidx == 4'hf) begin
            s_d.commit = 1'b0;
         end
      end
      s_d.div = s_q.div + 2'h1;
      if (ff_pop) begin
         s_d.mem[ff_out.addr] = ff_out.data;
      end
      if (s_q.busy) begin
         if (s_q.pcnt < 32'(WC_CYC)) begin
            s_d.pcnt = s_q.pcnt + 32'h1;
         end
         if (s_q.pcnt >= 32'(WC_CYC - 1) && !s_q.commit && !ff_out_valid) begin
            s_d.busy = 1'b0;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign reset_n_level = s_q.lo;
   assign reset_n_oe    = s_q.rst_oe;
   assign reset_hi      = s_q.rst_act;
   assign sda_level     = s_q.lo;
   assign sda_oe        = s_q.sda_oe;
   assign prog_busy     = s_q.busy;

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   a_supply_drop: assert property (!pg_s |=> reset_hi && reset_n_oe)
      else $error("supply low without reset");
   a_purst_load: assert property (pg_s && $past(!pg_s) |-> s_q.rcnt == PURST_CYC)
      else $error("power-up timeout not loaded");
   a_ext_edge: assert property (ext_fall |=> s_q.rcnt == PURST_CYC ##1 reset_hi)
      else $error("external reset edge did not reload timeout");
   a_mr_hold: assert property (s_q.mr_low |=> s_q.rcnt == PURST_CYC && reset_hi)
      else $error("manual reset not held");
   a_mr_glitch: assert property (mr_s && !s_q.mr_low |=> !s_q.mr_low [*2])
      else $error("manual reset taken without low input");
   a_wd_cleared: assert property (reset_hi |-> s_q.wdcnt == 32'h0)
      else $error("watchdog counts during reset");
   a_wd_edge: assert property (mon_edge |=> s_q.wdcnt == 32'h0)
      else $error("watchdog not cleared by edge");
   a_reset_abort: assert property (reset_hi |=> s_q.st == IES_IDLE && !sda_oe)
      else $error("transaction alive during reset");
   a_busy_nack: assert property (s_q.busy && s_q.st == IES_RX && s_q.ph == IES_PH_ADDR
      && scl_fall && s_q.bcnt == 4'h8 && !s_q.rst_act && !start_c && !stop_c
      |=> !sda_oe && s_q.st == IES_WAIT)
      else $error("address acknowledged while programming");
   a_wp_nack: assert property (wp_s && s_q.st == IES_RX && s_q.ph == IES_PH_DATA
      && scl_fall && s_q.bcnt == 4'h8 && !s_q.rst_act && !start_c && !stop_c
      |=> !sda_oe && $stable(s_q.pend))
      else $error("protected data byte acknowledged");
   a_page_step: assert property (s_q.st == IES_RX && s_d.st == IES_ACK
      && s_q.ph == IES_PH_DATA |=> s_q.ptr[7:4] == $past(s_q.ptr[7:4])
      && s_q.ptr[3:0] == $past(s_q.ptr[3:0]) + 4'h1)
      else $error("page address step wrong");
   a_prog_bound: assert property (s_q.busy |-> s_q.pcnt < WC_CYC)
      else $error("programming overran its cycle");

   c_page_write: cover property (s_q.commit && s_q.pend == 16'hffff);
   c_read_ack: cover property (s_q.st == IES_TXACK && s_q.acked ##1 s_q.st == IES_TX);
   c_wd_reset: cover property (wd_to ##1 reset_hi);
   c_ext_reset: cover property (ext_fall);
endmodule : ies_top

/* File: verification/ies_mst.sv */
// I2C bus master model: drives SCL and releases or pulls an open-drain SDA.
// Assumes the bench resolves SDA with a pull-up; steps on ref_clk falls.
`timescale 1ns/1ps
module ies_mst (
   // Clock
   input  wire logic ref_clk,
   // Bus
   input  wire logic sda_wire,
   output logic      scl,
   output logic      sda_rel
);
   initial begin
      scl = 1'b1;
      sda_rel = 1'b1;
   end
   task automatic w(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : w
   // SCL period 160 ns: 4 cycles low, 4 high; the slave answers 3 cycles after a fall
   task automatic bit_io(input logic b, output logic r);
      scl = 1'b0;
      w(2);
      sda_rel = b;
      w(2);
      scl = 1'b1;
      w(2);
      r = sda_wire;
      w(2);
   endtask : bit_io
   task automatic cond(input logic s0, input logic s1);
      logic r;
      bit_io(s0, r);
      sda_rel = s1;
      w(4);
   endtask : cond
   task automatic start();
      cond(1'b1, 1'b0);
   endtask : start
   task automatic stop();
      cond(1'b0, 1'b1);
   endtask : stop
   task automatic xfer(input logic [7:0] tx, input logic mack,
                       output logic [7:0] rx, output logic ack);
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], rx[i]);
      end
      bit_io(mack, ack);
   endtask : xfer
endmodule : ies_mst

/* File: verification/test_ies_top.sv */
// Self-checking bench of the supervisor top, with an I2C master model.
// Assumes ies_pkg, ies_top and ies_mst are compiled before this file.
`timescale 1ns/1ps
module test_ies_top;
   import ies_pkg::*;
   localparam int unsigned PURST = 200;
   localparam int unsigned WD    = 2000;
   localparam int unsigned WC    = 200;
   typedef struct packed {
      logic [7:0] wa;
      logic [7:0] d;
      logic       wp;
   } ies_row_type;
   logic        ref_clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        supply_good = 1'b0;
   logic        manual_reset_n = 1'b1;
   logic        ext_rst_n = 1'b1;
   logic        watchdog_kick_input = 1'b0;
   logic        write_protect = 1'b0;
   logic        kick_en = 1'b0;
   logic        wd_sel = 1'b1;
   logic        reset_n_level, reset_n_oe, reset_hi, reset_n_sense;
   logic        scl, sda_rel, sda_level, sda_oe, prog_busy, sda_wire;
   logic [7:0]  exp_mem [256];
   int          num_errors = 0;
   int          n_compared = 0;
   ies_row_type rows [4] = '{'{8'h00, 8'h5a, 1'b0}, '{8'hff, 8'ha5, 1'b0},
                             '{8'h10, 8'h3c, 1'b1}, '{8'h7f, 8'h81, 1'b0}};

   // Open-drain wires, both pulled up
   assign sda_wire = sda_rel & ~(sda_oe & ~sda_level);
   assign reset_n_sense = ext_rst_n & ~(reset_n_oe & ~reset_n_level);
   always #10 ref_clk = ~ref_clk;

   ies_top #(.PURST_CYC(PURST), .WD_CYC(WD), .WC_CYC(WC)) ies_top_inst (
      .ref_clk(ref_clk), .rst_n(rst_n), .supply_good(supply_good),
      .manual_reset_n(manual_reset_n), .reset_n_sense(reset_n_sense),
      .reset_n_level(reset_n_level), .reset_n_oe(reset_n_oe), .reset_hi(reset_hi),
      .watchdog_kick_input(watchdog_kick_input), .wd_watch_kick(wd_sel), .scl(scl),
      .sda_sense(sda_wire), .sda_level(sda_level), .sda_oe(sda_oe),
      .write_protect(write_protect), .prog_busy(prog_busy));
   ies_mst m (.ref_clk(ref_clk), .sda_wire(sda_wire), .scl(scl), .sda_rel(sda_rel));

   // ---------
   // Checks and bus steps
   // ---------
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      n_compared++;
      if (g !== e) begin
         num_errors++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // Bounded wait for reset_hi (s=1) or prog_busy (s=0) to reach lv
   task automatic wt(input logic s, input logic lv, input int n);
      logic v;
      v = s ? reset_hi : prog_busy;
      for (int i = 0; i < n && v !== lv; i++) begin
         @(negedge ref_clk);
         v = s ? reset_hi : prog_busy;
      end
      chk(s ? "reset_hi" : "prog_busy", {7'h0, lv}, {7'h0, v});
      if (s) chk("reset_n_sense", {7'h0, ~lv}, {7'h0, reset_n_sense});
   endtask : wt
   task automatic snd(input logic [7:0] d, input logic e);
      logic [7:0] r;
      logic       k;
      m.xfer(d, 1'b1, r, k);
      chk("ack", {7'h0, e}, {7'h0, k});
   endtask : snd
   task automatic hdr(input logic [7:0] a, input logic e);
      m.start();
      snd(a, e);
   endtask : hdr
   task automatic rdseq(input logic [7:0] a, input int n);
      logic [7:0] r;
      logic       k;
      hdr(8'ha0, 1'b0);
      snd(a, 1'b0);
      hdr(8'ha1, 1'b0);
      for (int i = 0; i < n; i++) begin
         m.xfer(8'hff, i == n - 1, r, k);
         chk("read data", exp_mem[a + 8'(i)], r);
      end
      m.stop();
   endtask : rdseq
   task automatic close_out();
      if (num_errors == 0 && n_compared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : close_out

   // Kicks keep the watchdog quiet outside its own test
   always begin
      repeat (256) @(negedge ref_clk);
      if (kick_en) watchdog_kick_input = ~watchdog_kick_input;
   end
   initial begin
      repeat (40000) @(posedge ref_clk);
      num_errors++;
      close_out();
   end

   // ---------
   // Main sequence
   // ---------
   initial begin
      foreach (exp_mem[a]) exp_mem[a] = 8'h00;
      repeat (10) @(negedge ref_clk);
      rst_n = 1'b1;
      wt(1'b1, 1'b1, 10);
      repeat (50) @(negedge ref_clk);
      wt(1'b1, 1'b1, 0);
      supply_good = 1'b1;
      repeat (PURST - 20) @(negedge ref_clk);
      wt(1'b1, 1'b1, 0);
      wt(1'b1, 1'b0, 40);
      kick_en = 1'b1;
      foreach (rows[i]) begin
         write_protect = rows[i].wp;
         hdr(8'ha0, 1'b0);
         snd(rows[i].wa, 1'b0);
         snd(rows[i].d, rows[i].wp);
         m.stop();
         wt(1'b0, ~rows[i].wp, 0);
         if (!rows[i].wp) begin
            exp_mem[rows[i].wa] = rows[i].d;
            hdr(8'ha0, 1'b1);
            m.stop();
            wt(1'b0, 1'b0, WC);
         end
         write_protect = 1'b0;
         rdseq(rows[i].wa, 1);
      end
      hdr(8'hb0, 1'b1);
      m.stop();
      hdr(8'ha0, 1'b0);
      snd(8'h2e, 1'b0);
      for (int k = 0; k < 18; k++) begin
         snd(8'h40 + 8'(k), 1'b0);
         exp_mem[{4'h2, 4'(4'he + k)}] = 8'h40 + 8'(k);
      end
      m.stop();
      wt(1'b0, 1'b1, 0);
      wt(1'b0, 1'b0, WC + 100);
      rdseq(8'h20, 16);
      rdseq(8'hff, 2);
      hdr(8'ha0, 1'b0);
      snd(8'h06, 1'b0);
      snd(8'h77, 1'b0);
      m.stop();
      exp_mem[8'h06] = 8'h77;
      supply_good = 1'b0;
      wt(1'b1, 1'b1, 6);
      wt(1'b0, 1'b1, 0);
      wt(1'b0, 1'b0, WC);
      hdr(8'ha0, 1'b1);
      m.stop();
      wt(1'b0, 1'b0, 0);
      supply_good = 1'b1;
      wt(1'b1, 1'b0, PURST + 40);
      rdseq(8'h06, 1);
      ext_rst_n = 1'b0;
      repeat (10) @(negedge ref_clk);
      wt(1'b1, 1'b1, 0);
      ext_rst_n = 1'b1;
      repeat (PURST - 30) @(negedge ref_clk);
      wt(1'b1, 1'b1, 0);
      wt(1'b1, 1'b0, 60);
      manual_reset_n = 1'b0;
      repeat (PURST + 50) @(negedge ref_clk);
      wt(1'b1, 1'b1, 0);
      manual_reset_n = 1'b1;
      repeat (PURST - 20) @(negedge ref_clk);
      wt(1'b1, 1'b1, 0);
      wt(1'b1, 1'b0, 60);
      manual_reset_n = 1'b0;
      repeat (4) @(negedge ref_clk);
      manual_reset_n = 1'b1;
      repeat (20) @(negedge ref_clk);
      wt(1'b1, 1'b0, 0);
      kick_en = 1'b0;
      @(negedge ref_clk);
      watchdog_kick_input = ~watchdog_kick_input;
      repeat (WD - 50) @(negedge ref_clk);
      wt(1'b1, 1'b0, 0);
      wt(1'b1, 1'b1, 60);
      wt(1'b1, 1'b0, PURST + 40);
      repeat (WD - 50) @(negedge ref_clk);
      wt(1'b1, 1'b0, 0);
      // SDA-watching variant: kick toggles no longer count, bus edges do
      wd_sel = 1'b0;
      kick_en = 1'b1;
      m.start();
      m.stop();
      repeat (WD - 100) @(negedge ref_clk);
      wt(1'b1, 1'b0, 0);
      wt(1'b1, 1'b1, 200);
      close_out();
   end
endmodule : test_ies_top
